// ===== rtl/isr_cfg.svh
// Purpose: Offsets-free constants for the status reporting block
// Assumes: Single 20 MHz clock, synchronous active-high reset
// Notes: Bit positions, reset values and the restart gap length
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH
// Status byte bit positions
`define ISR_STB_ERRQ_BIT 2
`define ISR_STB_DOUBT_BIT 3
`define ISR_STB_MAV_BIT 4
`define ISR_STB_ESB_BIT 5
`define ISR_STB_RQS_BIT 6
`define ISR_STB_ACTIVITY_SUMMARY_BIT 7
// Standard event bit positions
`define ISR_SE_OPC_BIT 0
`define ISR_SE_DDE_BIT 3
`define ISR_SE_EXE_BIT 4
`define ISR_SE_CME_BIT 5
`define ISR_SE_PON_BIT 7
// Operation activity bit positions
`define ISR_OP_TUB_BIT 3
`define ISR_OP_TEST_RUNNING_BIT 4
`define ISR_OP_PAM_BIT 6
`define ISR_OP_AAD_BIT 7
`define ISR_OP_ASE_BIT 8
`define ISR_OP_EMM_BIT 9
`define ISR_OP_EDI_BIT 10
`define ISR_OP_PATTERN_LOAD_BUSY_BIT 11
`define ISR_OP_INI_BIT 12
// Reset values
`define ISR_SE_RESET 8'h80
`define ISR_EN8_RESET 8'h00
`define ISR_EN16_RESET 16'h0000
// Gap held low on measure restart, in cycles
`define ISR_TEST_RUNNING_GAP_CYC 1
`endif

// ===== rtl/isr_pkg.sv
// Purpose: Types for the status reporting block
// Assumes: Header supplies bit positions and reset values; state codes are set here
// Notes: Nothing here is imported; use isr_pkg::name
package isr_pkg;
  // Measure flag tracker states
  typedef enum logic [2:0] {
    ISR_M_IDLE = 3'b001,
    ISR_M_GAP = 3'b010,
    ISR_M_RUN = 3'b100
  } isr_test_running_e;
  // Tracker state
  typedef struct packed {
    isr_test_running_e st;
    logic flag;
  } isr_test_running_s;
  // Main block state
  typedef struct packed {
    logic [7:0] std_event;
    logic [7:0] std_enable;
    logic [7:0] srq_enable;
    logic [15:0] op_enable;
    logic [6:0] poll_byte;
    logic poll_rqs;
    logic [7:0] query_byte;
    logic [7:0] esr_data;
    logic esr_valid;
    logic srq_line;
  } isr_main_s;
endpackage

// ===== rtl/isr_test_running_flag.sv
// Purpose: Port-measuring busy flag with restart dip
// Assumes: start and restart are one-cycle pulses, stop ends it
// Notes: Restart drops the flag for a short gap, then raises it
`include "isr_cfg.svh"
module isr_test_running_flag (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic test_running_start,
  input wire logic test_running_stop,
  output logic test_running
);
  // Registered state and its next copy
  isr_pkg::isr_test_running_s q;
  isr_pkg::isr_test_running_s next_q;

  // Next state logic
  always_comb begin
    next_q = q;
    case (q.st)
      isr_pkg::ISR_M_IDLE: begin
        if (test_running_start) begin
          next_q.st = isr_pkg::ISR_M_RUN;
          next_q.flag = 1'b1;
        end
      end
      isr_pkg::ISR_M_RUN: begin
        if (test_running_stop) begin
          next_q.st = isr_pkg::ISR_M_IDLE;
          next_q.flag = 1'b0;
        end else if (test_running_start) begin
          next_q.st = isr_pkg::ISR_M_GAP;
          next_q.flag = 1'b0;
        end
      end
      isr_pkg::ISR_M_GAP: begin
        // Gap lasts one cycle, then flag returns
        next_q.st = isr_pkg::ISR_M_RUN;
        next_q.flag = 1'b1;
        if (test_running_stop) begin
          next_q.st = isr_pkg::ISR_M_IDLE;
          next_q.flag = 1'b0;
        end
      end
      default: begin
        next_q.st = isr_pkg::ISR_M_IDLE;
        next_q.flag = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '{st: isr_pkg::ISR_M_IDLE, flag: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign test_running = q.flag;

  AST_TEST_RUNNING_DIP: assert property (@(posedge sys_clk) disable iff (rst)
    (q.flag && test_running_start && !test_running_stop) |=> !test_running ##1 (test_running || $past(test_running_stop)))
    else $error("Measure flag did not dip on restart");
  AST_TEST_RUNNING_RISE: assert property (@(posedge sys_clk) disable iff (rst)
    (q.st == isr_pkg::ISR_M_IDLE && test_running_start) |=> test_running)
    else $error("Measure flag did not rise at start");
  COV_TEST_RUNNING_RESTART: cover property (@(posedge sys_clk) disable iff (rst)
    q.flag && test_running_start);
endmodule

// ===== rtl/isr_status_top.sv
// Purpose: Status byte, standard event and operation activity reporting
// Assumes: Inputs synchronous to sys_clk; one command strobe per cycle
// Notes: Enable registers written through strobes with data; no bus
`include "isr_cfg.svh"
// How it works
// - request flag when byte AND enable nonzero
// - request flag sits at status bit 6
// - five latched events ORed into summary
// - event summary sits at status bit 5
// - bit 2 set while error queue nonempty
// - bit 3 doubtful summary, held zero
// - bit 4 set when output message waits
// - serial poll returns seven bits plus request
// - query puts master summary at bit 6
// - bit 7 carries activity summary
// - event bit 0 done, bit 7 power-up
// - bits 5,4,3 command, run, device faults
// - activity bits 3,4,6,7 busy flags
// - activity bits 8 to 12 busy flags
// - measuring flag rises, dips on restart
// - event query read clears all bits except events set in that same cycle
module isr_status_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic error_backlog_flag,
  input wire logic message_available,
  input wire logic all_ops_done,
  input wire logic device_specific_fault,
  input wire logic run_fault,
  input wire logic command_error,
  input wire logic tub_curve_busy,
  input wire logic test_running_start,
  input wire logic test_running_stop,
  input wire logic four_level_ber_busy,
  input wire logic auto_tune_busy,
  input wire logic auto_seek_busy,
  input wire logic eye_margin_busy,
  input wire logic eye_outline_busy,
  input wire logic pattern_load_busy,
  input wire logic startup_busy,
  input wire logic srq_enable_wr,
  input wire logic std_enable_wr,
  input wire logic op_enable_wr,
  input wire logic [15:0] wr_data,
  input wire logic esr_read,
  output logic [6:0] poll_byte,
  output logic poll_rqs,
  output logic [7:0] status_byte,
  output logic [7:0] standard_event_latch,
  output logic esr_valid,
  output logic [15:0] operation_activity_status,
  output logic [7:0] srq_enable,
  output logic [7:0] std_enable,
  output logic [15:0] op_enable,
  output logic service_request
);
  // Full state and its next copy
  isr_pkg::isr_main_s q;
  isr_pkg::isr_main_s next_q;
  // Measure flag from the tracker
  logic test_running;
  // Live activity vector
  logic [15:0] activity;
  // Registered activity vector
  logic [15:0] activity_q;
  // Live summaries
  logic [7:0] stb_core;
  logic master_summary;

  // Masked OR of two bytes
  function automatic logic masked_any8(input logic [7:0] a, input logic [7:0] m);
    masked_any8 = |(a & m);
  endfunction

  // Port measuring flag tracker
  isr_test_running_flag u_test_running (
    .sys_clk(sys_clk),
    .rst(rst),
    .test_running_start(test_running_start),
    .test_running_stop(test_running_stop),
    .test_running(test_running)
  );

  // Activity vector assembly
  always_comb begin
    activity = 16'h0000;
    activity[`ISR_OP_TUB_BIT] = tub_curve_busy;
    activity[`ISR_OP_TEST_RUNNING_BIT] = test_running;
    activity[`ISR_OP_PAM_BIT] = four_level_ber_busy;
    activity[`ISR_OP_AAD_BIT] = auto_tune_busy;
    activity[`ISR_OP_ASE_BIT] = auto_seek_busy;
    activity[`ISR_OP_EMM_BIT] = eye_margin_busy;
    activity[`ISR_OP_EDI_BIT] = eye_outline_busy;
    activity[`ISR_OP_PATTERN_LOAD_BUSY_BIT] = pattern_load_busy;
    activity[`ISR_OP_INI_BIT] = startup_busy;
  end

  // Status byte core without bit 6
  always_comb begin
    stb_core = 8'h00;
    stb_core[`ISR_STB_ERRQ_BIT] = error_backlog_flag;
    stb_core[`ISR_STB_DOUBT_BIT] = 1'b0;
    stb_core[`ISR_STB_MAV_BIT] = message_available;
    stb_core[`ISR_STB_ESB_BIT] = masked_any8(q.std_event, q.std_enable);
    stb_core[`ISR_STB_ACTIVITY_SUMMARY_BIT] = |(activity_q & q.op_enable);
    master_summary = masked_any8(stb_core, q.srq_enable);
  end

  // Next state logic
  always_comb begin
    next_q = q;
    // Enable register writes
    if (srq_enable_wr) begin
      next_q.srq_enable = wr_data[7:0];
    end
    if (std_enable_wr) begin
      next_q.std_enable = wr_data[7:0];
    end
    if (op_enable_wr) begin
      next_q.op_enable = wr_data;
    end
    // Query read returns value, then clears
    next_q.esr_valid = esr_read;
    if (esr_read) begin
      next_q.esr_data = q.std_event;
      next_q.std_event = 8'h00;
    end
    // done event, set wins over clear
    if (all_ops_done) begin
      next_q.std_event[`ISR_SE_OPC_BIT] = 1'b1;
    end
    // fault events, set wins over clear
    if (device_specific_fault) begin
      next_q.std_event[`ISR_SE_DDE_BIT] = 1'b1;
    end
    if (run_fault) begin
      next_q.std_event[`ISR_SE_EXE_BIT] = 1'b1;
    end
    if (command_error) begin
      next_q.std_event[`ISR_SE_CME_BIT] = 1'b1;
    end
    next_q.poll_byte = {stb_core[7], stb_core[5:0]};
    next_q.poll_rqs = master_summary;
    next_q.query_byte = stb_core | (master_summary ? 8'h40 : 8'h00);
    next_q.srq_line = master_summary;
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q.std_event <= `ISR_SE_RESET;
      q.std_enable <= `ISR_EN8_RESET;
      q.srq_enable <= `ISR_EN8_RESET;
      q.op_enable <= `ISR_EN16_RESET;
      q.poll_byte <= 7'h00;
      q.poll_rqs <= 1'b0;
      q.query_byte <= 8'h00;
      q.esr_data <= 8'h00;
      q.esr_valid <= 1'b0;
      q.srq_line <= 1'b0;
      activity_q <= 16'h0000;
    end else begin
      q <= next_q;
      activity_q <= activity;
    end
  end

  // Outputs straight from flip-flops
  assign poll_byte = q.poll_byte;
  assign poll_rqs = q.poll_rqs;
  assign status_byte = q.query_byte;
  assign standard_event_latch = q.esr_data;
  assign esr_valid = q.esr_valid;
  assign operation_activity_status = activity_q;
  assign srq_enable = q.srq_enable;
  assign std_enable = q.std_enable;
  assign op_enable = q.op_enable;
  assign service_request = q.srq_line;

  // Output and event register checks on the system clock

  AST_RQS_FOLLOWS: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 poll_rqs == |(status_byte & 8'hBF & $past(srq_enable)))
    else $error("Request flag wrong");

  AST_QUERY_BIT6: assert property (@(posedge sys_clk) disable iff (rst)
    status_byte[6] == poll_rqs)
    else $error("Query bit 6 differs from request flag");

  AST_ERRQ_BIT: assert property (@(posedge sys_clk) disable iff (rst)
    error_backlog_flag |=> status_byte[2])
    else $error("Error queue bit not set");

  AST_ERRQ_CLR: assert property (@(posedge sys_clk) disable iff (rst)
    !error_backlog_flag |=> !status_byte[2])
    else $error("Error queue bit stuck high");

  AST_DOUBT_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
    !status_byte[3])
    else $error("Doubtful summary not zero");

  AST_MAV_BIT: assert property (@(posedge sys_clk) disable iff (rst)
    message_available |=> status_byte[4] && poll_byte[4])
    else $error("Message bit not set");

  AST_MAV_CLR: assert property (@(posedge sys_clk) disable iff (rst)
    !message_available |=> !status_byte[4])
    else $error("Message bit stuck high");

  AST_ESB_BIT: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 status_byte[5] == $past(|(q.std_event & q.std_enable)))
    else $error("Event summary wrong");

  AST_PON_RESET: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> q.std_event[`ISR_SE_PON_BIT])
    else $error("Power-up event missing after reset");

  AST_OPC_SET: assert property (@(posedge sys_clk) disable iff (rst)
    all_ops_done |=> q.std_event[`ISR_SE_OPC_BIT])
    else $error("Done event not latched");

  AST_DDE_SET: assert property (@(posedge sys_clk) disable iff (rst)
    device_specific_fault |=> q.std_event[`ISR_SE_DDE_BIT])
    else $error("Device fault not latched");

  AST_EXE_SET: assert property (@(posedge sys_clk) disable iff (rst)
    run_fault |=> q.std_event[`ISR_SE_EXE_BIT])
    else $error("Run fault not latched");

  AST_CME_SET: assert property (@(posedge sys_clk) disable iff (rst)
    command_error |=> q.std_event[5])
    else $error("Command error not latched");

  AST_ESR_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    (esr_read && !all_ops_done && !device_specific_fault && !run_fault && !command_error)
    |=> q.std_event == 8'h00 && esr_valid && standard_event_latch == $past(q.std_event))
    else $error("Event read did not clear");

  AST_ESR_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 esr_valid == $past(esr_read))
    else $error("Event read valid pulse wrong");

  AST_SRQ_EN_WR: assert property (@(posedge sys_clk) disable iff (rst)
    srq_enable_wr |=> srq_enable == $past(wr_data[7:0]))
    else $error("Request enable not written");

  AST_OP_EN_WR: assert property (@(posedge sys_clk) disable iff (rst)
    op_enable_wr |=> op_enable == $past(wr_data))
    else $error("Activity enable not written");

  AST_ACTIVITY_SUMMARY_SUM: assert property (@(posedge sys_clk) disable iff (rst)
    (|(activity & q.op_enable) && !op_enable_wr) |=> ##1 status_byte[7])
    else $error("Activity summary missing");

  AST_ACT_MAP: assert property (@(posedge sys_clk) disable iff (rst)
    startup_busy |=> operation_activity_status[12])
    else $error("Startup busy not shown");

  AST_PAM_MAP: assert property (@(posedge sys_clk) disable iff (rst)
    four_level_ber_busy |=> operation_activity_status[`ISR_OP_PAM_BIT])
    else $error("Four-level busy not shown");

  AST_TEST_RUNNING_MAP: assert property (@(posedge sys_clk) disable iff (rst)
    test_running |=> operation_activity_status[`ISR_OP_TEST_RUNNING_BIT])
    else $error("Measuring flag not shown");

  AST_ACT_UNUSED: assert property (@(posedge sys_clk) disable iff (rst)
    (operation_activity_status & 16'hE027) == 16'h0000)
    else $error("Unused activity bit set");

  // Main scenario covers
  COV_SRQ: cover property (@(posedge sys_clk) disable iff (rst) service_request);
  COV_ESR_READ: cover property (@(posedge sys_clk) disable iff (rst) esr_read && q.std_event != 8'h00);
  COV_ACTIVITY_SUMMARY: cover property (@(posedge sys_clk) disable iff (rst) status_byte[7]);
endmodule

// ===== verif/isr_ctl_model.sv
// Purpose: Remote controller model for the status reporting block
// Assumes: Strobes change at the falling edge of sys_clk
// Notes: Idle write data shows the inverse of the last word
module isr_ctl_model (
  input wire logic sys_clk,
  input wire logic [7:0] status_byte,
  input wire logic esr_valid,
  input wire logic [7:0] standard_event_latch,
  output logic srq_enable_wr,
  output logic std_enable_wr,
  output logic op_enable_wr,
  output logic [15:0] wr_data,
  output logic esr_read
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet strobes from time zero
  initial begin
    srq_enable_wr = 1'b0;
    std_enable_wr = 1'b0;
    op_enable_wr = 1'b0;
    esr_read = 1'b0;
    wr_data = 16'h0000;
  end
  // Write one enable: sel 0 request, 1 event, 2 activity
  task automatic wr(input logic [1:0] sel, input logic [15:0] d);
    @(negedge sys_clk);
    wr_data = d;
    srq_enable_wr = (sel == 2'd0);
    std_enable_wr = (sel == 2'd1);
    op_enable_wr = (sel == 2'd2);
    @(negedge sys_clk);
    srq_enable_wr = 1'b0;
    std_enable_wr = 1'b0;
    op_enable_wr = 1'b0;
    wr_data = ~d;
  endtask
  // Event query, value taken with the valid pulse
  task automatic esr_get(output logic [7:0] v, output logic ok);
    ok = 1'b0;
    v = 8'h00;
    @(negedge sys_clk);
    esr_read = 1'b1;
    @(negedge sys_clk);
    esr_read = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (esr_valid === 1'b1) begin
        v = standard_event_latch;
        ok = 1'b1;
      end else begin
        @(negedge sys_clk);
      end
    end
  endtask
  task automatic fetch(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge sys_clk);
      ok = (status_byte[4] === 1'b1);
    end
  endtask
endmodule

// ===== verif/instrument_status_reporting_tb.sv
// Purpose: Self-checking bench for the status reporting block
// Assumes: Inputs change at the falling edge of sys_clk
// Notes: Partner model plays the remote controller
`define CHK(got, exp, what) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %0t %s", $time, what); \
    end \
  end
module instrument_status_reporting_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EPOS[4] = '{0, 3, 4, 5}; // Event bit of each event input
  localparam int BPOS[8] = '{3, 6, 7, 8, 9, 10, 11, 12}; // Activity bit of each busy
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic err_q = 1'b0;
  logic msg_av = 1'b0;
  logic [3:0] evt = 4'h0; // Done, device, run, command
  logic [7:0] busy = 8'h00;
  logic m_start = 1'b0;
  logic m_stop = 1'b0;
  logic srq_wr, std_wr, op_wr, esr_rd, esr_v, service_request_flag, srv, ok, seen;
  logic [15:0] wdat, oas, op_en;
  logic [6:0] pb;
  logic [7:0] stb, sel, srq_en, std_en, v;
  int fails = 0;
  int checked = 0;
  // Free-running clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  isr_status_top u_dut (.sys_clk(sys_clk), .rst(rst), .error_backlog_flag(err_q),
    .message_available(msg_av), .all_ops_done(evt[0]), .device_specific_fault(evt[1]),
    .run_fault(evt[2]), .command_error(evt[3]), .tub_curve_busy(busy[0]),
    .test_running_start(m_start), .test_running_stop(m_stop), .four_level_ber_busy(busy[1]),
    .auto_tune_busy(busy[2]), .auto_seek_busy(busy[3]), .eye_margin_busy(busy[4]),
    .eye_outline_busy(busy[5]), .pattern_load_busy(busy[6]), .startup_busy(busy[7]),
    .srq_enable_wr(srq_wr), .std_enable_wr(std_wr), .op_enable_wr(op_wr),
    .wr_data(wdat), .esr_read(esr_rd), .poll_byte(pb), .poll_rqs(service_request_flag),
    .status_byte(stb), .standard_event_latch(sel), .esr_valid(esr_v),
    .operation_activity_status(oas), .srq_enable(srq_en), .std_enable(std_en),
    .op_enable(op_en), .service_request(srv));
  isr_ctl_model u_ctl (.sys_clk(sys_clk), .status_byte(stb), .esr_valid(esr_v),
    .standard_event_latch(sel), .srq_enable_wr(srq_wr), .std_enable_wr(std_wr),
    .op_enable_wr(op_wr), .wr_data(wdat), .esr_read(esr_rd));
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Exhausted wait ends the run
  task automatic need(input logic good);
    if (good !== 1'b1) begin
      fails++;
      $display("mismatch %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Main sequence
  initial begin
    cyc(16);
    rst = 1'b0;
    cyc(1);
    `CHK({srq_en, std_en, op_en, stb}, 40'h0, "reset values")
    u_ctl.esr_get(v, ok);
    need(ok);
    `CHK(v, 8'h80, "power-up event")
    u_ctl.esr_get(v, ok);
    need(ok);
    `CHK(v, 8'h00, "read clears")
    for (int i = 0; i < 4; i++) begin
      evt[i] = 1'b1;
      cyc(1);
      evt[i] = 1'b0;
      u_ctl.esr_get(v, ok);
      need(ok);
      `CHK(v, 8'h01 << EPOS[i], "event bit")
    end
    // Event summary drives request
    u_ctl.wr(2'd1, 16'h0020);
    u_ctl.wr(2'd0, 16'h0020);
    `CHK(std_en, 8'h20, "event enable")
    evt[3] = 1'b1;
    cyc(1);
    evt[3] = 1'b0;
    cyc(3);
    `CHK(stb, 8'h60, "query byte")
    `CHK({pb, service_request_flag, srv}, 9'h083, "poll byte")
    u_ctl.esr_get(v, ok);
    need(ok);
    `CHK(v, 8'h20, "command event read")
    cyc(3);
    `CHK(stb, 8'h00, "summary after read")
    // Queue bits
    u_ctl.wr(2'd0, 16'h0014);
    err_q = 1'b1;
    cyc(3);
    `CHK(stb, 8'h44, "error queue")
    err_q = 1'b0;
    msg_av = 1'b1;
    u_ctl.fetch(ok);
    need(ok);
    cyc(2);
    `CHK(stb, 8'h50, "message waiting")
    msg_av = 1'b0;
    // Busy flags and activity summary
    u_ctl.wr(2'd2, 16'hFFFF);
    u_ctl.wr(2'd0, 16'h0080);
    `CHK(op_en, 16'hFFFF, "activity enable")
    for (int i = 0; i < 8; i++) begin
      busy = 8'h01 << i;
      cyc(3);
      `CHK(oas, 16'h0001 << BPOS[i], "busy bit")
      `CHK(stb, 8'hC0, "activity summary")
    end
    u_ctl.wr(2'd2, 16'h0008);
    busy = 8'h10;
    cyc(3);
    `CHK(stb, 8'h00, "masked activity")
    busy = 8'h00;
    // Measure flag with restart
    m_start = 1'b1;
    cyc(1);
    m_start = 1'b0;
    cyc(1);
    `CHK(oas[4], 1'b1, "measure starts")
    m_start = 1'b1;
    cyc(1);
    m_start = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      seen = seen | (oas[4] === 1'b0);
    end
    `CHK({seen, oas[4]}, 2'b11, "restart dip")
    m_stop = 1'b1;
    cyc(1);
    m_stop = 1'b0;
    cyc(3);
    `CHK(oas, 16'h0000, "measure stops")
    // Mid-run reset brings back the power-up event
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    `CHK({srq_en, std_en, op_en}, 32'h0, "enables after reset")
    u_ctl.esr_get(v, ok);
    need(ok);
    `CHK(v, 8'h80, "power-up after reset")
    wrap_up();
  end
endmodule
